/* bench/accel_serial_slave_port_bench.sv */
`timescale 1ns/10ps
module accel_serial_slave_port_bench;
   logic        clk;
   logic        reset_n;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [7:0]  fmt_q;
   logic        two_wire_sel;
   logic        frame_active;
   logic [7:0]  cmd_seen;
   logic [31:0] d;
   int          cmd_bits;
   int          fails;
   int          comparisons;

   assp_link_if assp_link_if_inst ();
   assp_host assp_host_inst (
      .clk       (clk),
      .reset_n   (reset_n),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .link      (assp_link_if_inst)
   );
   assp_dev assp_dev_inst (
      .link         (assp_link_if_inst),
      .clk          (clk),
      .reset_n      (reset_n),
      .fmt_q        (fmt_q),
      .two_wire_sel (two_wire_sel),
      .frame_active (frame_active)
   );
   assp_link_asserts assp_link_asserts_inst (
      .clk          (clk),
      .reset_n      (reset_n),
      .sclk         (assp_link_if_inst.sclk),
      .cs_n         (assp_link_if_inst.cs_n),
      .host_sdi_out (assp_link_if_inst.host_sdi_out),
      .host_sdi_oe  (assp_link_if_inst.host_sdi_oe),
      .dev_sdio_out (assp_link_if_inst.dev_sdio_out),
      .dev_sdio_oe  (assp_link_if_inst.dev_sdio_oe),
      .dev_sdo_out  (assp_link_if_inst.dev_sdo_out),
      .dev_sdo_oe   (assp_link_if_inst.dev_sdo_oe)
   );

   // ==========
   // Command byte as seen on the wire; count restarts as select rises
   always @(posedge assp_link_if_inst.sclk or posedge assp_link_if_inst.cs_n) begin
      if (assp_link_if_inst.cs_n) begin
         cmd_bits = 0;
      end else if (cmd_bits < 8) begin
         cmd_seen = {cmd_seen[6:0], assp_link_if_inst.sdi_line};
         cmd_bits++;
      end
   end

   // ==========
   // Helpers
   task automatic test_done;
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // One whole frame; polls status under a bound
   task automatic xfer(input logic r, input logic mb, input logic [1:0] len,
                       input logic [5:0] a, input logic [31:0] tx, input logic three);
      logic [31:0] s;
      int          n;
      wr(assp_pkg::ADDR_OFS, {26'h0, a});
      wr(assp_pkg::TXDATA_OFS, tx);
      wr(assp_pkg::CTRL_OFS, {23'h0, three, 2'h0, len, 1'b0, mb, r, 1'b1});
      repeat (8) @(posedge clk);
      chk("frame_active", 32'h1, {31'h0, frame_active});
      chk("two_wire_sel", 32'h0, {31'h0, two_wire_sel});
      // Settings written mid-frame must be ignored
      wr(assp_pkg::TXDATA_OFS, ~tx);
      n = 0;
      s = 32'h1;
      while (s[assp_pkg::STAT_BUSY] !== 1'b0 && n < 500) begin
         rd(assp_pkg::STATUS_OFS, s);
         n++;
      end
      chk("busy", 32'h0, {31'h0, s[assp_pkg::STAT_BUSY]});
      chk("done", 32'h1, {31'h0, s[assp_pkg::STAT_DONE]});
      rd(assp_pkg::TXDATA_OFS, s);
      chk("txdata kept", tx, s);
      rd(assp_pkg::CTRL_OFS, s);
      chk("ctrl", {23'h0, three, 2'h0, len, 1'b0, mb, r, 1'b0}, s);
      chk("command", {24'h0, r, mb, a}, {24'h0, cmd_seen});
      wr(assp_pkg::STATUS_OFS, 32'h2);
      repeat (3) @(posedge clk);
      chk("two_wire_sel idle", 32'h1, {31'h0, two_wire_sel});
   endtask

   // ==========
   // Scenarios
   task automatic t_reset;
      chk("fmt_q reset", 32'h0, {24'h0, fmt_q});
      chk("reg_rdata reset", 32'h0, reg_rdata);
      rd(8'h40, d);
      chk("unmapped", 32'h0, d);
   endtask
   task automatic t_single;
      xfer(1'b0, 1'b0, 2'h0, 6'h10, 32'hA5, 1'b0);
      rd(assp_pkg::RXDATA_OFS, d);
      chk("rx after write", 32'h0, d);
      xfer(1'b1, 1'b0, 2'h0, 6'h10, 32'h0, 1'b0);
      rd(assp_pkg::RXDATA_OFS, d);
      chk("single read", 32'hA5, {24'h0, d[7:0]});
   endtask
   // Burst across the top of the map wraps to zero
   task automatic t_burst;
      xfer(1'b0, 1'b1, 2'h2, 6'h3E, 32'h00C3_B2A1, 1'b0);
      xfer(1'b1, 1'b1, 2'h2, 6'h3E, 32'h0, 1'b0);
      rd(assp_pkg::RXDATA_OFS, d);
      chk("burst read", 32'hC3_B2A1, {8'h0, d[23:0]});
   endtask
   task automatic t_no_burst;
      xfer(1'b0, 1'b0, 2'h1, 6'h20, 32'h5A77, 1'b0);
      xfer(1'b1, 1'b1, 2'h1, 6'h20, 32'h0, 1'b0);
      rd(assp_pkg::RXDATA_OFS, d);
      chk("no burst", 32'h0077, {16'h0, d[15:0]});
   endtask
   task automatic t_three_wire;
      xfer(1'b0, 1'b0, 2'h0, assp_pkg::FMT_REG_ADDR, 32'h40, 1'b0);
      chk("fmt_q three", 32'h40, {24'h0, fmt_q});
      xfer(1'b1, 1'b1, 2'h1, 6'h30, 32'h0, 1'b1);
      rd(assp_pkg::RXDATA_OFS, d);
      chk("three wire burst", 32'h4000, {16'h0, d[15:0]});
      xfer(1'b1, 1'b0, 2'h0, 6'h10, 32'h0, 1'b1);
      rd(assp_pkg::RXDATA_OFS, d);
      chk("three wire read", 32'hA5, {24'h0, d[7:0]});
      xfer(1'b0, 1'b0, 2'h0, assp_pkg::FMT_REG_ADDR, 32'h0, 1'b1);
      chk("fmt_q four", 32'h0, {24'h0, fmt_q});
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      reset_n     = 1'b0;
      reg_addr    = 8'h0;
      reg_wdata   = 32'h0;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      fails       = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      t_reset;
      t_single;
      t_burst;
      t_no_burst;
      t_three_wire;
      test_done;
   end
   // Ten frames of under a thousand cycles each fit well inside
   initial begin
      #200000;
      fails++;
      test_done;
   end
endmodule

/* bench/assp_link_asserts.sv */
`timescale 1ns/10ps
module assp_link_asserts (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic host_sdi_out,
   input wire logic host_sdi_oe,
   input wire logic dev_sdio_out,
   input wire logic dev_sdio_oe,
   input wire logic dev_sdo_out,
   input wire logic dev_sdo_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ==========
   // Frame shape
   sequence s_open; sclk ##1 !sclk; endsequence
   sequence s_low_half; !sclk[*8] ##1 !sclk ##1 sclk; endsequence
   property p_idle_high; cs_n |-> sclk; endproperty
   property p_open; $fell(cs_n) |-> s_open; endproperty
   property p_low_half; $fell(sclk) |=> s_low_half; endproperty
   property p_high_half; $rose(sclk) && !cs_n |=> sclk[*8]; endproperty
   property p_quiet; $rose(cs_n) |-> sclk && $past(sclk); endproperty
   property p_gap; $rose(cs_n) |=> cs_n[*8] ##1 cs_n[*7]; endproperty
   a_idle_high: assert property (p_idle_high) else $error("clock low while idle");
   a_open: assert property (p_open) else $error("bad frame opening");
   a_low_half: assert property (p_low_half) else $error("low half wrong");
   a_high_half: assert property (p_high_half) else $error("high half short");
   a_quiet: assert property (p_quiet) else $error("select rose with clock low");
   a_gap: assert property (p_gap) else $error("select gap short");
   // ==========
   // Data lines
   property p_host_launch;
      !cs_n && !$past(cs_n) && $changed(host_sdi_out) |-> $fell(sclk);
   endproperty
   // Device flops are on the falling edge, so changes land in the low half
   property p_dev_launch;
      !cs_n && ($changed(dev_sdio_out) || $changed(dev_sdo_out)) |-> !sclk;
   endproperty
   property p_no_clash; !(host_sdi_oe && dev_sdio_oe) && !(dev_sdio_oe && dev_sdo_oe);
   endproperty
   property p_release; cs_n |-> !dev_sdio_oe && !dev_sdo_oe; endproperty
   a_host_launch: assert property (p_host_launch) else $error("host data off fall");
   a_dev_launch: assert property (p_dev_launch) else $error("device data off fall");
   a_no_clash: assert property (p_no_clash) else $error("line contention");
   a_release: assert property (p_release) else $error("device drives deselected");
endmodule

/* hdl/assp_dev.sv */
`timescale 1ns/10ps
module assp_dev (
   assp_link_if.dev   link,
   input  wire logic  clk,
   input  wire logic  reset_n,
   output logic [7:0] fmt_q,
   output logic       two_wire_sel,
   output logic       frame_active
);

   // =========================================================
   // Link side, clocked by the serial clock
   // =========================================================
   logic       frame_rst_n;
   logic [2:0] bit_cnt_ff;
   logic       first_done_ff;
   logic       rw_ff;
   logic       mb_ff;
   logic       stop_ff;
   logic [5:0] ptr_ff;
   logic [6:0] in_sh_ff;
   logic [7:0] rd_sh_ff;
   logic [7:0] mem_ff [assp_pkg::REG_COUNT];
   logic       dout_ff;
   logic       sdo_oe_ff;
   logic       sdio_oe_ff;
   logic       byte_end;
   logic [7:0] byte_in;
   logic       wr_en;
   logic       three_wire;
   logic       rd_active;

   // Deselect ends the frame even with the clock stopped
   assign frame_rst_n = reset_n & ~link.cs_n;
   assign byte_end    = (bit_cnt_ff == 3'h7);
   assign byte_in     = {in_sh_ff, link.dev_sdi};
   assign wr_en       = byte_end & first_done_ff & ~rw_ff & ~stop_ff;
   assign three_wire  = mem_ff[assp_pkg::FMT_REG_ADDR][assp_pkg::WIRE_SEL_BIT];
   assign rd_active   = first_done_ff & rw_ff & ~stop_ff;

   // Capture on rising edges
   always_ff @(posedge link.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt_ff <= 3'h0;
         in_sh_ff   <= 7'h00;
      end else begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         in_sh_ff   <= byte_in[6:0];
      end
   end

   always_ff @(posedge link.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         first_done_ff <= 1'b0;
         rw_ff         <= 1'b0;
         mb_ff         <= 1'b0;
         stop_ff       <= 1'b0;
         ptr_ff        <= 6'h00;
         rd_sh_ff      <= 8'h00;
      end else if (byte_end && !first_done_ff) begin
         // Command byte: direction, burst flag, pointer
         first_done_ff <= 1'b1;
         rw_ff         <= byte_in[assp_pkg::CMD_RW_BIT];
         mb_ff         <= byte_in[assp_pkg::CMD_MB_BIT];
         ptr_ff        <= byte_in[5:0];
         rd_sh_ff      <= mem_ff[byte_in[5:0]];
      end else if (byte_end) begin
         if (mb_ff) begin
            // Every further eight clocks step the pointer
            ptr_ff   <= ptr_ff + 6'h01;
            rd_sh_ff <= mem_ff[ptr_ff + 6'h01];
         end else begin
            stop_ff  <= 1'b1;
            rd_sh_ff <= 8'h00;
         end
      end else begin
         rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
      end
   end

   // Register contents survive frames; only system reset clears them
   always_ff @(posedge link.sclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < assp_pkg::REG_COUNT; i++) begin
            mem_ff[i] <= assp_pkg::REG_RESET;
         end
      end else if (wr_en) begin
         mem_ff[ptr_ff] <= byte_in;
      end
   end

   // Launch on falling edges; release at once on deselect
   always_ff @(negedge link.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         dout_ff    <= 1'b0;
         sdo_oe_ff  <= 1'b0;
         sdio_oe_ff <= 1'b0;
      end else begin
         dout_ff    <= rd_sh_ff[7];
         sdo_oe_ff  <= rd_active & ~three_wire;
         sdio_oe_ff <= rd_active & three_wire;
      end
   end

   // SPI slave only; no master logic exists
   assign link.dev_sdo_out  = dout_ff;
   assign link.dev_sdo_oe   = sdo_oe_ff;
   assign link.dev_sdio_out = dout_ff;
   assign link.dev_sdio_oe  = sdio_oe_ff;

   // =========================================================
   // System side status
   // =========================================================
   logic       cs_meta_ff;
   logic       cs_sync_ff;
   logic [7:0] fmt_meta_ff;
   logic [7:0] fmt_sync_ff;
   logic [7:0] fmt_q_ff;
   logic       two_wire_ff;
   logic       active_ff;

   // Format word only changes inside a frame, so it is taken only while the
   // synced select shows the link idle; no bit is caught mid-change
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_meta_ff  <= 1'b1;
         cs_sync_ff  <= 1'b1;
         fmt_meta_ff <= assp_pkg::FMT_RESET;
         fmt_sync_ff <= assp_pkg::FMT_RESET;
      end else begin
         cs_meta_ff  <= link.cs_n;
         cs_sync_ff  <= cs_meta_ff;
         if (cs_sync_ff) begin
            fmt_meta_ff <= mem_ff[assp_pkg::FMT_REG_ADDR];
         end
         fmt_sync_ff <= fmt_meta_ff;
      end
   end

   // Select high means two-wire mode
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fmt_q_ff    <= assp_pkg::FMT_RESET;
         two_wire_ff <= 1'b1;
         active_ff   <= 1'b0;
      end else begin
         fmt_q_ff    <= fmt_sync_ff;
         two_wire_ff <= cs_sync_ff;
         active_ff   <= ~cs_sync_ff;
      end
   end

   assign fmt_q        = fmt_q_ff;
   assign two_wire_sel = two_wire_ff;
   assign frame_active = active_ff;

endmodule

/* hdl/assp_host.sv */
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module assp_host (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [7:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [31:0]  reg_rdata,
   assp_link_if.host         link
);

   // =========================================================
   // Helpers
   // =========================================================
   // Last bit index of a frame of command plus len+1 bytes
   function automatic logic [5:0] last_idx(input logic [1:0] len);
      logic [2:0] n;
      n = {1'b0, len} + 3'h2;
      return {n, 3'b000} - 6'h01;
   endfunction
   // In three-wire reads the host lets go after the command byte
   function automatic logic drive_bit(input logic three, input logic rd,
                                      input logic [5:0] idx);
      return !(three && rd && (idx >= assp_pkg::FIRST_DATA_IDX));
   endfunction
   // Position of a received bit: bytes low first, MSB first in each
   function automatic logic [4:0] rx_pos(input logic [5:0] idx);
      logic [5:0] d;
      d = idx - assp_pkg::FIRST_DATA_IDX;
      return {d[4:3], ~d[2:0]};
   endfunction

   // =========================================================
   // Control registers
   // =========================================================
   assp_pkg::assp_state_t state_ff;
   logic        rw_ff;
   logic        mb_ff;
   logic [1:0]  len_ff;
   logic        three_ff;
   logic [5:0]  addr_ff;
   logic [31:0] tx_ff;
   logic [31:0] rx_ff;
   logic        done_ff;
   logic [31:0] rdata_ff;
   logic        start;
   logic        busy;
   logic        finish;
   logic        done_clr;
   assign busy     = (state_ff != assp_pkg::ST_IDLE);
   assign start    = reg_wr && (reg_addr == assp_pkg::CTRL_OFS)
                     && reg_wdata[assp_pkg::CTRL_START] && !busy;
   assign done_clr = reg_wr && (reg_addr == assp_pkg::STATUS_OFS)
                     && reg_wdata[assp_pkg::STAT_DONE];
   // Settings are frozen while a frame runs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rw_ff    <= 1'b0;
         mb_ff    <= 1'b0;
         len_ff   <= 2'h0;
         three_ff <= 1'b0;
      end else if (reg_wr && !busy && (reg_addr == assp_pkg::CTRL_OFS)) begin
         rw_ff    <= reg_wdata[assp_pkg::CTRL_READ];
         mb_ff    <= reg_wdata[assp_pkg::CTRL_MB];
         len_ff   <= reg_wdata[assp_pkg::CTRL_LEN_LO +: 2];
         three_ff <= reg_wdata[assp_pkg::CTRL_3WIRE];
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_ff <= 6'h00;
         tx_ff   <= 32'h0000_0000;
      end else if (reg_wr && !busy) begin
         if (reg_addr == assp_pkg::ADDR_OFS) begin
            addr_ff <= reg_wdata[5:0];
         end
         if (reg_addr == assp_pkg::TXDATA_OFS) begin
            tx_ff <= reg_wdata;
         end
      end
   end
   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done_ff <= 1'b0;
      end else if (finish) begin
         done_ff <= 1'b1;
      end else if (done_clr) begin
         done_ff <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            assp_pkg::CTRL_OFS:   rdata_ff <= {23'h00_0000, three_ff, 2'h0, len_ff,
                                               1'b0, mb_ff, rw_ff, 1'b0};
            assp_pkg::ADDR_OFS:   rdata_ff <= {26'h000_0000, addr_ff};
            assp_pkg::TXDATA_OFS: rdata_ff <= tx_ff;
            assp_pkg::RXDATA_OFS: rdata_ff <= rx_ff;
            assp_pkg::STATUS_OFS: rdata_ff <= {30'h0000_0000, done_ff, busy};
            default:              rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign reg_rdata = rdata_ff;

   // =========================================================
   // Input synchronisers
   // =========================================================
   logic sdi_meta_ff;
   logic sdi_sync_ff;
   logic sdo_meta_ff;
   logic sdo_sync_ff;
   logic miso;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sdi_meta_ff <= 1'b1;
         sdi_sync_ff <= 1'b1;
         sdo_meta_ff <= 1'b1;
         sdo_sync_ff <= 1'b1;
      end else begin
         sdi_meta_ff <= link.sdi_line;
         sdi_sync_ff <= sdi_meta_ff;
         sdo_meta_ff <= link.sdo_line;
         sdo_sync_ff <= sdo_meta_ff;
      end
   end
   assign miso = three_ff ? sdi_sync_ff : sdo_sync_ff;
   // =========================================================
   // Frame engine
   // =========================================================
   logic [4:0]  cnt_ff;
   logic [5:0]  bit_cnt_ff;
   logic [39:0] sh_ff;
   logic        sclk_ff;
   logic        cs_n_ff;
   logic        mosi_ff;
   logic        mosi_oe_ff;
   logic        cnt_end;
   logic        last_bit;
   assign cnt_end  = (cnt_ff == 5'h01);
   assign last_bit = (bit_cnt_ff == last_idx(len_ff));
   assign finish   = (state_ff == assp_pkg::ST_GAP) && cnt_end;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= assp_pkg::ST_IDLE;
      end else begin
         unique case (state_ff)
            assp_pkg::ST_IDLE:  if (start) state_ff <= assp_pkg::ST_SETUP;
            assp_pkg::ST_SETUP: if (cnt_end) state_ff <= assp_pkg::ST_LOW;
            assp_pkg::ST_LOW:   if (cnt_end) state_ff <= assp_pkg::ST_HIGH;
            assp_pkg::ST_HIGH: begin
               if (cnt_end) begin
                  state_ff <= last_bit ? assp_pkg::ST_QUIET : assp_pkg::ST_LOW;
               end
            end
            assp_pkg::ST_QUIET: if (cnt_end) state_ff <= assp_pkg::ST_GAP;
            assp_pkg::ST_GAP:   if (cnt_end) state_ff <= assp_pkg::ST_IDLE;
            default:            state_ff <= assp_pkg::ST_IDLE;
         endcase
      end
   end
   // Half period from 5 MHz ceiling; also meets the 2 MHz floor
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 5'h00;
      end else if (start) begin
         cnt_ff <= assp_pkg::DELAY_CNT;
      end else if (cnt_end || cnt_ff == 5'h00) begin
         unique case (state_ff)
            assp_pkg::ST_SETUP: cnt_ff <= assp_pkg::HALF_CNT;
            assp_pkg::ST_LOW:   cnt_ff <= assp_pkg::HALF_CNT;
            assp_pkg::ST_HIGH:  cnt_ff <= last_bit ? assp_pkg::QUIET_CNT : assp_pkg::HALF_CNT;
            assp_pkg::ST_QUIET: cnt_ff <= assp_pkg::GAP_CNT;
            default:            cnt_ff <= 5'h00;
         endcase
      end else begin
         cnt_ff <= cnt_ff - 5'h01;
      end
   end
   // One address per frame; scattered registers need new frames
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sh_ff      <= 40'h00_0000_0000;
         bit_cnt_ff <= 6'h00;
      end else if (start) begin
         sh_ff      <= {reg_wdata[assp_pkg::CTRL_READ], reg_wdata[assp_pkg::CTRL_MB],
                        addr_ff, tx_ff[7:0], tx_ff[15:8], tx_ff[23:16], tx_ff[31:24]};
         bit_cnt_ff <= 6'h00;
      end else if (state_ff == assp_pkg::ST_HIGH && cnt_end) begin
         sh_ff      <= {sh_ff[38:0], 1'b0};
         bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
   end
   // Sample late in the high half; device output is stable there
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_ff <= 32'h0000_0000;
      end else if (start) begin
         rx_ff <= 32'h0000_0000;
      end else if (state_ff == assp_pkg::ST_HIGH && cnt_end && rw_ff
                   && bit_cnt_ff >= assp_pkg::FIRST_DATA_IDX) begin
         rx_ff[rx_pos(bit_cnt_ff)] <= miso;
      end
   end
   // Clock idles high, falls to launch, rises to capture
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_ff <= 1'b1;
      end else if (cnt_end && (state_ff == assp_pkg::ST_SETUP
                   || (state_ff == assp_pkg::ST_HIGH && !last_bit))) begin
         sclk_ff <= 1'b0;
      end else if (cnt_end && state_ff == assp_pkg::ST_LOW) begin
         sclk_ff <= 1'b1;
      end
   end

   // Select brackets every frame, high from reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_n_ff <= 1'b1;
      end else if (start) begin
         cs_n_ff <= 1'b0;
      end else if (state_ff == assp_pkg::ST_QUIET && cnt_end) begin
         cs_n_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mosi_ff    <= 1'b1;
         mosi_oe_ff <= 1'b0;
      end else if (start) begin
         mosi_ff    <= reg_wdata[assp_pkg::CTRL_READ];
         mosi_oe_ff <= 1'b1;
      end else if (state_ff == assp_pkg::ST_HIGH && cnt_end && !last_bit) begin
         mosi_ff    <= sh_ff[38];
         mosi_oe_ff <= drive_bit(three_ff, rw_ff, bit_cnt_ff + 6'h01);
      end else if (state_ff == assp_pkg::ST_QUIET && cnt_end) begin
         mosi_ff    <= 1'b1;
         mosi_oe_ff <= 1'b0;
      end
   end

   assign link.sclk         = sclk_ff;
   assign link.cs_n         = cs_n_ff;
   assign link.host_sdi_out = mosi_ff;
   assign link.host_sdi_oe  = mosi_oe_ff;

endmodule

/* hdl/assp_link_if.sv */
`timescale 1ns/10ps
interface assp_link_if;
   logic sclk;
   logic cs_n;
   logic host_sdi_out;
   logic host_sdi_oe;
   logic dev_sdio_out;
   logic dev_sdio_oe;
   logic dev_sdo_out;
   logic dev_sdo_oe;
   logic sdi_line;
   logic sdo_line;
   logic dev_sdi;

   // Undriven lines float to the pull-up level
   assign sdi_line = host_sdi_oe ? host_sdi_out : (dev_sdio_oe ? dev_sdio_out : 1'b1);
   assign sdo_line = dev_sdo_oe ? dev_sdo_out : 1'b1;
   // Input held high while deselected
   assign dev_sdi  = sdi_line | cs_n;

   modport dev (input sclk, input cs_n, input dev_sdi,
                output dev_sdio_out, output dev_sdio_oe,
                output dev_sdo_out, output dev_sdo_oe);
   modport host (output sclk, output cs_n, output host_sdi_out, output host_sdi_oe,
                 input sdi_line, input sdo_line);
endinterface

/* hdl/assp_pkg.sv */
package assp_pkg;

   // =========================================================
   // Device register map
   // =========================================================
   localparam logic [5:0] FMT_REG_ADDR  = 6'h31;
   localparam int         WIRE_SEL_BIT  = 6;
   localparam logic [7:0] FMT_RESET     = 8'h00;
   localparam logic [7:0] REG_RESET     = 8'h00;
   localparam int         REG_COUNT     = 64;

   // =========================================================
   // Frame layout
   // =========================================================
   localparam int         BYTE_BITS     = 8;
   localparam int         CMD_RW_BIT    = 7;
   localparam int         CMD_MB_BIT    = 6;
   localparam logic [5:0] FIRST_DATA_IDX = 6'h08;

   // =========================================================
   // Link timing
   // =========================================================
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SCLK_MAX_KHZ   = 5000;
   localparam int SCLK_PERIOD_NS = 1000000 / SCLK_MAX_KHZ;
   localparam int DELAY_NS       = 5;
   localparam int QUIET_NS       = 5;
   localparam int CS_GAP_NS      = 150;

   // Least times round up, never below one cycle
   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [4:0] HALF_CNT  = 5'(ceil_cyc(SCLK_PERIOD_NS / 2));
   localparam logic [4:0] DELAY_CNT = 5'(ceil_cyc(DELAY_NS));
   localparam logic [4:0] QUIET_CNT = 5'(ceil_cyc(QUIET_NS));
   localparam logic [4:0] GAP_CNT   = 5'(ceil_cyc(CS_GAP_NS));

   // =========================================================
   // Controller registers
   // =========================================================
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] ADDR_OFS    = 8'h04;
   localparam logic [7:0] TXDATA_OFS  = 8'h08;
   localparam logic [7:0] RXDATA_OFS  = 8'h0C;
   localparam logic [7:0] STATUS_OFS  = 8'h10;
   localparam int         CTRL_START  = 0;
   localparam int         CTRL_READ   = 1;
   localparam int         CTRL_MB     = 2;
   localparam int         CTRL_LEN_LO = 4;
   localparam int         CTRL_3WIRE  = 8;
   localparam int         STAT_BUSY   = 0;
   localparam int         STAT_DONE   = 1;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_SETUP = 3'h1,
      ST_LOW   = 3'h2,
      ST_HIGH  = 3'h3,
      ST_QUIET = 3'h4,
      ST_GAP   = 3'h5
   } assp_state_t;

endpackage
